// file: src/dpio_cfg.svh
`ifndef DPIO_CFG_SVH
`define DPIO_CFG_SVH

`define DPIO_PORT_W        8
`define DPIO_ADDR_W        16

`define DPIO_P6_LATCH_ADDR 16'h0006
`define DPIO_P7_LATCH_ADDR 16'h0007
`define DPIO_P6_DIR_ADDR   16'h000C
`define DPIO_P7_PIN_ADDR   16'h000D
`define DPIO_P7_SEG_ADDR   16'h002B

`define DPIO_P6_LATCH_RST  8'h00
`define DPIO_P6_DIR_RST    8'h00
`define DPIO_P7_LATCH_RST  8'hFF
`define DPIO_P7_SEG_RST    8'h00
`define DPIO_ZERO8         8'h00
`define DPIO_SYNC_RST      8'h00

`define DPIO_BIT_EXT_IRQ   3
`define DPIO_BIT_EVT_CNT   2
`define DPIO_BIT_EVT_CAP   1
`define DPIO_BIT_WAKE_A    4
`define DPIO_BIT_WAKE_B    5
`define DPIO_BIT_WAKE_C    6
`define DPIO_BIT_WAKE_D    7
`endif

// file: src/dpio_pkg.sv
`include "dpio_cfg.svh"
package dpio_pkg;

    typedef enum logic [3:0] {
        DPIO_MODE_OUT  = 4'h1,
        DPIO_MODE_DIN  = 4'h2,
        DPIO_MODE_AIN  = 4'h4,
        DPIO_MODE_ZERO = 4'h8
    } dpio_mode_t;

    typedef struct packed {
        logic [`DPIO_PORT_W-1:0] s1;
        logic [`DPIO_PORT_W-1:0] s2;
        logic [`DPIO_PORT_W-1:0] s3;
        logic [`DPIO_PORT_W-1:0] filt;
    } dpio_sync_t;

    typedef struct packed {
        logic [`DPIO_PORT_W-1:0] p6_latch;
        logic [`DPIO_PORT_W-1:0] p6_dir;
        logic [`DPIO_PORT_W-1:0] p7_latch;
        logic [`DPIO_PORT_W-1:0] p7_seg;
        logic [`DPIO_PORT_W-1:0] p6_in;
        logic [`DPIO_PORT_W-1:0] rd_data;
    } dpio_state_t;

endpackage : dpio_pkg

// file: src/dpio_sync.sv
`include "dpio_cfg.svh"
module dpio_sync
    import dpio_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic [`DPIO_PORT_W-1:0] pin_async,
    output logic      [`DPIO_PORT_W-1:0] pin_level
);

    dpio_sync_t st;
    dpio_sync_t next_st;
    logic [`DPIO_PORT_W-1:0] differ;

    // A bit moves only once stages two and three agree, filtering one-cycle glitches
    always_comb begin
        next_st      = st;
        differ       = st.s2 ^ st.s3;
        next_st.s1   = pin_async;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.filt = (st.s3 & ~differ) | (st.filt & differ);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '{s1: `DPIO_SYNC_RST, s2: `DPIO_SYNC_RST, s3: `DPIO_SYNC_RST,
                    filt: `DPIO_SYNC_RST};
        end else begin
            st <= next_st;
        end
    end

    assign pin_level = st.filt;

endmodule : dpio_sync

// file: src/dpio_top.sv
`include "dpio_cfg.svh"
module dpio_top
    import dpio_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic [`DPIO_ADDR_W-1:0] bus_addr,
    input  wire logic [`DPIO_PORT_W-1:0] bus_wr_data,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    output logic      [`DPIO_PORT_W-1:0] bus_rd_data,
    input  wire logic                    analog_input_disable,
    input  wire logic [`DPIO_PORT_W-1:0] p6_pin_in,
    output logic      [`DPIO_PORT_W-1:0] p6_pin_out,
    output logic      [`DPIO_PORT_W-1:0] p6_pin_oe,
    output logic      [`DPIO_PORT_W-1:0] p6_analog_select,
    output logic                         external_interrupt_zero,
    output logic                         event_count_input,
    output logic                         event_capture_input,
    output logic                         wakeup_key_input_a,
    output logic                         wakeup_key_input_b,
    output logic                         wakeup_key_input_c,
    output logic                         wakeup_key_input_d,
    input  wire logic [`DPIO_PORT_W-1:0] lcd_segment_drive,
    input  wire logic [`DPIO_PORT_W-1:0] p7_pin_in,
    output logic      [`DPIO_PORT_W-1:0] p7_pin_out,
    output logic      [`DPIO_PORT_W-1:0] p7_pin_oe,
    output logic      [`DPIO_PORT_W-1:0] p7_segment_select
);

    dpio_state_t             st;
    dpio_state_t             next_st;
    logic [`DPIO_PORT_W-1:0] p6_level;
    logic [`DPIO_PORT_W-1:0] p7_level;
    logic [`DPIO_PORT_W-1:0] p6_gated;
    dpio_mode_t              p6_mode [`DPIO_PORT_W];

    // Pins are asynchronous to sys_clk
    dpio_sync u_p6_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_async (p6_pin_in),
        .pin_level (p6_level)
    );

    dpio_sync u_p7_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_async (p7_pin_in),
        .pin_level (p7_level)
    );

    // Per-pin mode of the first port and the data its readers see
    genvar gi;
    generate
        for (gi = 0; gi < `DPIO_PORT_W; gi++) begin : g_p6_bit
            always_comb begin
                if (st.p6_dir[gi]) begin
                    p6_mode[gi] = DPIO_MODE_OUT;
                end else if (st.p6_latch[gi]) begin
                    p6_mode[gi] = DPIO_MODE_DIN;
                end else if (analog_input_disable) begin
                    p6_mode[gi] = DPIO_MODE_ZERO;
                end else begin
                    p6_mode[gi] = DPIO_MODE_AIN;
                end
            end

            always_comb begin
                case (p6_mode[gi])
                    DPIO_MODE_OUT: begin
                        p6_gated[gi] = p6_level[gi];
                    end
                    DPIO_MODE_DIN: begin
                        p6_gated[gi] = p6_level[gi];
                    end
                    DPIO_MODE_AIN: begin
                        p6_gated[gi] = 1'b0;
                    end
                    DPIO_MODE_ZERO: begin
                        p6_gated[gi] = 1'b0;
                    end
                    default: begin
                        p6_gated[gi] = 1'b0;
                    end
                endcase
            end

            assign p6_analog_select[gi] = (p6_mode[gi] == DPIO_MODE_AIN);
        end
    endgenerate

    always_comb begin
        next_st         = st;
        next_st.p6_in   = p6_gated;
        next_st.rd_data = `DPIO_ZERO8;
        if (bus_wr) begin
            case (bus_addr)
                `DPIO_P6_LATCH_ADDR: begin
                    next_st.p6_latch = bus_wr_data;
                end
                `DPIO_P6_DIR_ADDR: begin
                    next_st.p6_dir = bus_wr_data;
                end
                `DPIO_P7_LATCH_ADDR: begin
                    next_st.p7_latch = bus_wr_data;
                end
                `DPIO_P7_SEG_ADDR: begin
                    next_st.p7_seg = bus_wr_data;
                end
                default: begin
                    next_st.p7_seg = st.p7_seg;
                end
            endcase
        end
        if (bus_rd) begin
            case (bus_addr)
                `DPIO_P6_LATCH_ADDR: begin
                    // Pin levels, not the latch, which is why bit set or clear corrupts modes
                    next_st.rd_data = p6_gated;
                end
                `DPIO_P6_DIR_ADDR: begin
                    next_st.rd_data = st.p6_dir;
                end
                `DPIO_P7_LATCH_ADDR: begin
                    next_st.rd_data = st.p7_latch;
                end
                `DPIO_P7_PIN_ADDR: begin
                    // Segment pins return whatever the pin shows
                    next_st.rd_data = p7_level;
                end
                `DPIO_P7_SEG_ADDR: begin
                    next_st.rd_data = st.p7_seg;
                end
                default: begin
                    next_st.rd_data = `DPIO_ZERO8;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '{p6_latch: `DPIO_P6_LATCH_RST,
                    p6_dir:   `DPIO_P6_DIR_RST,
                    p7_latch: `DPIO_P7_LATCH_RST,
                    p7_seg:   `DPIO_P7_SEG_RST,
                    p6_in:    `DPIO_ZERO8,
                    rd_data:  `DPIO_ZERO8};
        end else begin
            st <= next_st;
        end
    end

    assign bus_rd_data = st.rd_data;

    // First port is push-pull; analog or input pins are simply not driven
    assign p6_pin_out = st.p6_latch;
    assign p6_pin_oe  = st.p6_dir;

    // Secondary inputs see only the qualified, registered data
    assign external_interrupt_zero = st.p6_in[`DPIO_BIT_EXT_IRQ];
    assign event_count_input       = st.p6_in[`DPIO_BIT_EVT_CNT];
    assign event_capture_input     = st.p6_in[`DPIO_BIT_EVT_CAP];
    assign wakeup_key_input_a      = st.p6_in[`DPIO_BIT_WAKE_A];
    assign wakeup_key_input_b      = st.p6_in[`DPIO_BIT_WAKE_B];
    assign wakeup_key_input_c      = st.p6_in[`DPIO_BIT_WAKE_C];
    assign wakeup_key_input_d      = st.p6_in[`DPIO_BIT_WAKE_D];

    // Second port I/O pins sink only, segment pins drive lcd_segment_drive: a latch one releases an I/O pin so it can serve as input
    assign p7_segment_select = st.p7_seg;
    assign p7_pin_out        = (st.p7_seg & lcd_segment_drive) | (~st.p7_seg & st.p7_latch);
    assign p7_pin_oe         = st.p7_seg | ~st.p7_latch;

    // Checks
    default clocking dpio_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_p6_dir;
        bus_wr && (bus_addr == `DPIO_P6_DIR_ADDR);
    endsequence

    sequence s_wr_p6_latch;
        bus_wr && (bus_addr == `DPIO_P6_LATCH_ADDR);
    endsequence

    sequence s_rd_p6;
        bus_rd && (bus_addr == `DPIO_P6_LATCH_ADDR);
    endsequence

    sequence s_wr_p7_latch;
        bus_wr && (bus_addr == `DPIO_P7_LATCH_ADDR);
    endsequence

    sequence s_rd_p7_latch;
        bus_rd && (bus_addr == `DPIO_P7_LATCH_ADDR);
    endsequence

    sequence s_rd_p7_pin;
        bus_rd && (bus_addr == `DPIO_P7_PIN_ADDR);
    endsequence

    sequence s_wr_p7_seg;
        bus_wr && (bus_addr == `DPIO_P7_SEG_ADDR);
    endsequence

    sequence s_rd_p6_dir;
        bus_rd && (bus_addr == `DPIO_P6_DIR_ADDR);
    endsequence

    sequence s_wr_p7_pin;
        bus_wr && (bus_addr == `DPIO_P7_PIN_ADDR);
    endsequence

    sequence s_rd_p7_seg;
        bus_rd && (bus_addr == `DPIO_P7_SEG_ADDR);
    endsequence

    sequence s_ext_int_high_input;
        !st.p6_dir[`DPIO_BIT_EXT_IRQ] && st.p6_latch[`DPIO_BIT_EXT_IRQ]
            && p6_pin_in[`DPIO_BIT_EXT_IRQ];
    endsequence

    property p_dir_write_sets_oe;
        logic [`DPIO_PORT_W-1:0] d;
        (s_wr_p6_dir, d = bus_wr_data) |=> (p6_pin_oe == d);
    endproperty

    property p_latch_write_drives;
        logic [`DPIO_PORT_W-1:0] d;
        (s_wr_p6_latch, d = bus_wr_data) |=> ((p6_pin_out & p6_pin_oe) == (d & p6_pin_oe));
    endproperty

    AST_P6_DIR_PER_BIT: assert property (p_dir_write_sets_oe)
        else $error("first port enable does not follow the direction write");

    AST_P6_OUTPUT_LATCH: assert property (p_latch_write_drives)
        else $error("first port output pin does not show the latch");

    AST_RESET_STATE: assert property (disable iff (1'b0)
        rst |-> (p6_pin_oe == `DPIO_P6_DIR_RST) && (p6_pin_out == `DPIO_P6_LATCH_RST)
            && (p7_pin_out == `DPIO_P7_LATCH_RST) && (p7_segment_select == `DPIO_P7_SEG_RST)
            && (st.p6_in == `DPIO_ZERO8))
        else $error("port state wrong during reset");

    AST_RESET_INPUT_ZERO: assert property (disable iff (1'b0)
        $fell(rst) && analog_input_disable |-> (p6_gated == `DPIO_ZERO8)
            ##1 (st.p6_in == `DPIO_ZERO8))
        else $error("first port input data not zero after reset");

    AST_P6_DIGITAL_INPUT: assert property (
        s_ext_int_high_input [*7] |-> external_interrupt_zero)
        else $error("digital input level did not reach the interrupt input");

    AST_P6_FIXED_ZERO: assert property (
        s_rd_p6 ##0 analog_input_disable |=>
            ((bus_rd_data & ~$past(st.p6_dir) & ~$past(st.p6_latch)) == `DPIO_ZERO8))
        else $error("fixed-zero input bit read as one");

    AST_P6_ANALOG_READ_ZERO: assert property (
        s_rd_p6 |=> ((bus_rd_data & $past(p6_analog_select)) == `DPIO_ZERO8))
        else $error("analog input bit read as one");

    AST_P6_OUTPUT_READ: assert property (
        s_rd_p6 |=> (((bus_rd_data ^ $past(p6_level)) & $past(st.p6_dir)) == `DPIO_ZERO8))
        else $error("output pin bit does not read back the pin level");

    AST_ANALOG_SELECT: assert property (
        analog_input_disable |-> (p6_analog_select == `DPIO_ZERO8)
            and ((p6_analog_select & (st.p6_dir | st.p6_latch)) == `DPIO_ZERO8))
        else $error("analog select raised on a non-analog pin");

    AST_P7_SEGMENT_MODE: assert property (
        s_wr_p7_seg |=> (p7_segment_select == $past(bus_wr_data))
            && ((p7_pin_oe & p7_segment_select) == p7_segment_select)
            && ((p7_pin_out & p7_segment_select) == (lcd_segment_drive & p7_segment_select)))
        else $error("segment pins not handed to the segment driver");

    AST_P7_LATCH_READBACK: assert property (
        s_wr_p7_latch ##1 s_rd_p7_latch |=> (bus_rd_data == $past(bus_wr_data, 2)))
        else $error("second port latch readback mismatch");

    AST_P6_DIR_READBACK: assert property (
        s_wr_p6_dir ##1 s_rd_p6_dir |=> (bus_rd_data == $past(bus_wr_data, 2)))
        else $error("first port direction readback mismatch");

    AST_P7_SEG_READBACK: assert property (
        s_wr_p7_seg ##1 s_rd_p7_seg |=> (bus_rd_data == $past(bus_wr_data, 2)))
        else $error("segment select readback mismatch");

    AST_P7_PIN_READ: assert property (
        s_rd_p7_pin |=> (bus_rd_data == $past(p7_level)))
        else $error("second port pin read does not show the pin level");

    AST_P7_PIN_READ_ONLY: assert property (
        s_wr_p7_pin |=> $stable(st.p7_latch) && $stable(st.p7_seg)
            && $stable(st.p6_dir) && $stable(st.p6_latch))
        else $error("write to the pin input address changed a register");

    AST_RD_DATA_ONE_CYCLE: assert property (
        !bus_rd |=> (bus_rd_data == `DPIO_ZERO8))
        else $error("read data present without a read");

endmodule : dpio_top

// file: testbench/dpio_pin_model.sv
module dpio_pin_model (
    p6_pin_out,
    p6_pin_oe,
    p7_pin_out,
    p7_pin_oe,
    ext6,
    ext7,
    lcd_val,
    p6_pin_in,
    p7_pin_in,
    lcd_segment_drive
);
    timeunit 1ns;
    timeprecision 1ns;

    input  wire logic [7:0] p6_pin_out;
    input  wire logic [7:0] p6_pin_oe;
    input  wire logic [7:0] p7_pin_out;
    input  wire logic [7:0] p7_pin_oe;
    input  wire logic [7:0] ext6;
    input  wire logic [7:0] ext7;
    input  wire logic [7:0] lcd_val;
    output logic      [7:0] p6_pin_in;
    output logic      [7:0] p7_pin_in;
    output logic      [7:0] lcd_segment_drive;

    // Driven bits win over the outside world; undriven bits see the board level
    assign p6_pin_in         = (p6_pin_out & p6_pin_oe) | (ext6 & ~p6_pin_oe);
    assign p7_pin_in         = (p7_pin_out & p7_pin_oe) | (ext7 & ~p7_pin_oe);
    // Segment values held steady so segment pins never toggle under a read
    assign lcd_segment_drive = lcd_val;
endmodule : dpio_pin_model

// file: testbench/test_dual_port_io_analog_segment.sv
`include "dpio_cfg.svh"
module test_dual_port_io_analog_segment;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk;
    logic        rst;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wr_data;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_rd_data;
    logic        analog_input_disable;
    logic [7:0]  p6_pin_in;
    logic [7:0]  p6_pin_out;
    logic [7:0]  p6_pin_oe;
    logic [7:0]  p6_analog_select;
    logic [7:0]  lcd_segment_drive;
    logic [7:0]  p7_pin_in;
    logic [7:0]  p7_pin_out;
    logic [7:0]  p7_pin_oe;
    logic [7:0]  p7_segment_select;
    logic [7:0]  ext6;
    logic [7:0]  ext7;
    logic [7:0]  lcd_val;
    wire  [6:0]  sec;
    int          errors;
    int          n_compared;

    dpio_top u_dut (
        .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wr_data(bus_wr_data),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rd_data(bus_rd_data),
        .analog_input_disable(analog_input_disable), .p6_pin_in(p6_pin_in),
        .p6_pin_out(p6_pin_out), .p6_pin_oe(p6_pin_oe), .p6_analog_select(p6_analog_select),
        .external_interrupt_zero(sec[2]), .event_count_input(sec[1]),
        .event_capture_input(sec[0]), .wakeup_key_input_a(sec[3]),
        .wakeup_key_input_b(sec[4]), .wakeup_key_input_c(sec[5]),
        .wakeup_key_input_d(sec[6]), .lcd_segment_drive(lcd_segment_drive),
        .p7_pin_in(p7_pin_in), .p7_pin_out(p7_pin_out), .p7_pin_oe(p7_pin_oe),
        .p7_segment_select(p7_segment_select)
    );

    dpio_pin_model u_pins (
        .p6_pin_out(p6_pin_out), .p6_pin_oe(p6_pin_oe), .p7_pin_out(p7_pin_out),
        .p7_pin_oe(p7_pin_oe), .ext6(ext6), .ext7(ext7), .lcd_val(lcd_val),
        .p6_pin_in(p6_pin_in), .p7_pin_in(p7_pin_in), .lcd_segment_drive(lcd_segment_drive)
    );

    always #50 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Leaves the strobe up so a following access may start at the very next edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_addr    <= a;
        bus_wr_data <= d;
        bus_wr      <= 1'b1;
        bus_rd      <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        bus_wr   <= 1'b0;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rd_data & m, exp);
        @(posedge sys_clk);
        #1;
        chk(bus_rd_data, 8'h00);
        @(posedge sys_clk);
    endtask : rd

    task automatic idle();
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : idle

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step

    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        finish_test();
    end

    initial begin
        sys_clk = 1'b0;
        // Nonblocking so the flops are already waiting on the reset edge
        rst <= 1'b1;
        bus_addr = 16'h0000;
        bus_wr_data = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        analog_input_disable = 1'b1;
        ext6 = 8'h00;
        ext7 = 8'hFF;
        lcd_val = 8'h00;
        errors = 0;
        n_compared = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(p6_pin_oe, 8'h00);
        chk(p6_pin_out, 8'h00);
        chk(p7_pin_out, 8'hFF);
        chk(p7_pin_oe, 8'h00);
        chk(p6_analog_select, 8'h00);
        chk({1'b0, sec}, 8'h00);
        @(posedge sys_clk);
        rd(`DPIO_P6_LATCH_ADDR, 8'h00);
        rd(`DPIO_P6_DIR_ADDR, 8'h00);
        rd(`DPIO_P7_LATCH_ADDR, 8'hFF);
        rd(`DPIO_P7_SEG_ADDR, 8'h00);
        // Mixed first port: low nibble outputs, upper nibble inputs and analog
        ext6 <= 8'h7F;
        wr(`DPIO_P6_DIR_ADDR, 8'h0F);
        wr(`DPIO_P6_LATCH_ADDR, 8'hA5);
        idle();
        #1;
        chk(p6_pin_oe, 8'h0F);
        chk(p6_pin_out, 8'hA5);
        step(8);
        rd(`DPIO_P6_LATCH_ADDR, 8'h25);
        analog_input_disable <= 1'b0;
        step(2);
        #1;
        chk(p6_analog_select, 8'h50);
        chk(p6_pin_oe, 8'h0F);
        step(1);
        rd(`DPIO_P6_LATCH_ADDR, 8'h25);
        // All pins inputs; bits 1 to 7 feed the secondary functions
        analog_input_disable <= 1'b1;
        ext6 <= 8'h98;
        wr(`DPIO_P6_DIR_ADDR, 8'h00);
        wr(`DPIO_P6_LATCH_ADDR, 8'hFF);
        idle();
        step(8);
        #1;
        chk({1'b0, sec}, 8'h4C);
        step(1);
        rd(`DPIO_P6_LATCH_ADDR, 8'h98);
        wr(`DPIO_P6_LATCH_ADDR, 8'h00);
        idle();
        step(8);
        #1;
        chk({1'b0, sec}, 8'h00);
        step(1);
        rd(`DPIO_P6_LATCH_ADDR, 8'h00);
        // Second port: low nibble segments, the rest general I/O
        ext7 <= 8'hC3;
        lcd_val <= 8'h3C;
        wr(`DPIO_P7_LATCH_ADDR, 8'h55);
        wr(`DPIO_P7_SEG_ADDR, 8'h0F);
        idle();
        #1;
        chk(p7_segment_select, 8'h0F);
        chk(p7_pin_out, 8'h5C);
        chk(p7_pin_oe, 8'hAF);
        step(8);
        // Segment bits masked off since their readback is not defined
        rd(`DPIO_P7_PIN_ADDR, 8'h40, 8'hF0);
        rd(`DPIO_P7_LATCH_ADDR, 8'h55);
        rd(`DPIO_P7_SEG_ADDR, 8'h0F);
        wr(`DPIO_P7_SEG_ADDR, 8'h00);
        wr(`DPIO_P7_LATCH_ADDR, 8'hF0);
        idle();
        step(8);
        #1;
        chk(p7_pin_out, 8'hF0);
        chk(p7_pin_oe, 8'h0F);
        step(1);
        rd(`DPIO_P7_PIN_ADDR, 8'hC0);
        // Read-only and unmapped places, back to back
        wr(`DPIO_P7_PIN_ADDR, 8'h00);
        wr(16'h0031, 8'hAA);
        rd(16'h0031, 8'h00);
        rd(`DPIO_P7_LATCH_ADDR, 8'hF0);
        rd(`DPIO_P7_PIN_ADDR, 8'hC0);
        rd(`DPIO_P6_DIR_ADDR, 8'h00);
        // Write then read at once, then a reset in mid-run restores the defaults
        wr(`DPIO_P6_DIR_ADDR, 8'hF0);
        rd(`DPIO_P6_DIR_ADDR, 8'hF0);
        wr(`DPIO_P7_SEG_ADDR, 8'hA0);
        rd(`DPIO_P7_SEG_ADDR, 8'hA0);
        wr(`DPIO_P7_LATCH_ADDR, 8'h3C);
        rd(`DPIO_P7_LATCH_ADDR, 8'h3C);
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        step(1);
        #1;
        chk(p6_pin_oe, 8'h00);
        chk(p7_pin_out, 8'hFF);
        chk(p7_segment_select, 8'h00);
        chk({1'b0, sec}, 8'h00);
        step(1);
        rd(`DPIO_P7_LATCH_ADDR, 8'hFF);
        finish_test();
    end
endmodule : test_dual_port_io_analog_segment
